// ---- rtl/rrpd_pkg.sv ----
// shared constants and types of the readback pointer decode block
package rrpd_pkg;

   // ****************************************
   // pointer byte fields
   // ****************************************
   localparam logic [3:0]  MODE_CFG      = 4'h0;
   localparam logic [3:0]  MODE_REGRD    = 4'h7;
   localparam logic [3:0]  SEL_NOP       = 4'h0;
   localparam logic [3:0]  SEL_SEQ       = 4'h2;
   localparam logic [3:0]  SEL_EXT_LO    = 4'h3;
   localparam logic [3:0]  SEL_EXT_HI    = 4'hD;

   // ****************************************
   // reset values and writable masks
   // ****************************************
   localparam logic [7:0]  PTR_RST       = 8'h70;
   localparam logic [15:0] NOP_RST       = 16'h0000;
   localparam logic [15:0] SEQ_RST       = 16'h0000;
   localparam logic [15:0] NOP_WMASK     = 16'h07FF;
   localparam logic [15:0] SEQ_WMASK     = 16'h00FF;

   // ****************************************
   // bus framing
   // ****************************************
   localparam logic [3:0]  BYTE_BITS     = 4'h8;
   localparam logic [6:0]  DEV_ADDR_DEF  = 7'h2A;
   localparam logic [1:0]  WIDX_PTR      = 2'h0;
   localparam logic [1:0]  WIDX_HI       = 2'h1;
   localparam logic [1:0]  WIDX_LO       = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK,
      ST_WR,
      ST_RD,
      ST_RACK
   } rrpd_state_t;

endpackage : rrpd_pkg

// ---- rtl/rrpd_regbank.sv ----
// pointer register, control registers and registered readback mux
`timescale 1ns/10ps
module rrpd_regbank (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        ptr_wr,
   input  wire logic [7:0]  ptr_byte,
   input  wire logic        data_wr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] ext_rdata,
   output logic      [15:0] rd_word,
   output logic      [3:0]  readback_sel,
   output logic      [15:0] conv_chan_sel
);

   typedef struct packed {
      logic [7:0]  ptr;
      logic [15:0] no_operation_register;
      logic [15:0] seq;
      logic [15:0] rdata;
   } rrpd_bank_t;

   localparam rrpd_bank_t BANK_RST = '{ptr: rrpd_pkg::PTR_RST,
      no_operation_register: rrpd_pkg::NOP_RST, seq: rrpd_pkg::SEQ_RST, rdata: 16'h0000};

   rrpd_bank_t q;
   rrpd_bank_t d;
   logic       rb_mode;
   logic       cfg_mode;

   assign rb_mode  = (q.ptr[7:4] == rrpd_pkg::MODE_REGRD);
   assign cfg_mode = (q.ptr[7:4] == rrpd_pkg::MODE_CFG);

   always_comb begin
      d = q;
      if (ptr_wr) begin
         d.ptr = ptr_byte;                                   // RQ1
      end
      // register writes only land while the pointer is in config mode
      if (data_wr && cfg_mode) begin
         if (q.ptr[3:0] == rrpd_pkg::SEL_NOP) begin
            d.no_operation_register = wdata & rrpd_pkg::NOP_WMASK;             // RQ4 RQ5
         end else if (q.ptr[3:0] == rrpd_pkg::SEL_SEQ) begin
            d.seq = wdata & rrpd_pkg::SEQ_WMASK;             // RQ6
         end
      end
      // other pointer modes have no data path here and read as zero
      d.rdata = 16'h0000;
      if (rb_mode) begin
         if (q.ptr[3:0] == rrpd_pkg::SEL_NOP) begin
            d.rdata = q.no_operation_register;                                 // RQ2
         end else if (q.ptr[3:0] == rrpd_pkg::SEL_SEQ) begin
            d.rdata = q.seq;                                 // RQ2
         end else if (q.ptr[3:0] >= rrpd_pkg::SEL_EXT_LO &&
                      q.ptr[3:0] <= rrpd_pkg::SEL_EXT_HI) begin
            d.rdata = ext_rdata;                             // RQ2 RQ3
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         q <= BANK_RST;
      end else begin
         q <= d;
      end
   end

   assign rd_word       = q.rdata;
   assign readback_sel  = q.ptr[3:0];
   assign conv_chan_sel = q.seq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   ptr_capture_a: assert property ( // RQ1
      ptr_wr && ptr_byte[7:4] == rrpd_pkg::MODE_REGRD |=>
         rb_mode && readback_sel == $past(ptr_byte[3:0]))
      else $error("readback pointer not taken");

   nop_readback_a: assert property ( // RQ2
      rb_mode && readback_sel == rrpd_pkg::SEL_NOP |=>
         rd_word == $past(q.no_operation_register))
      else $error("noop readback mismatch");

   ext_readback_a: assert property ( // RQ3
      rb_mode && readback_sel >= rrpd_pkg::SEL_EXT_LO &&
      readback_sel <= rrpd_pkg::SEL_EXT_HI |=> rd_word == $past(ext_rdata))
      else $error("external readback mismatch");

   nop_write_a: assert property ( // RQ4
      data_wr && cfg_mode && readback_sel == rrpd_pkg::SEL_NOP |=>
         q.no_operation_register[10:0] == $past(wdata[10:0]) && $stable(conv_chan_sel))
      else $error("noop write wrong");

   nop_reserved_a: assert property ( // RQ5
      rb_mode && readback_sel == rrpd_pkg::SEL_NOP |=> rd_word[15:11] == 5'h00)
      else $error("noop reserved bits set");

   seq_write_a: assert property ( // RQ6
      data_wr && cfg_mode && readback_sel == rrpd_pkg::SEL_SEQ |=>
         conv_chan_sel == ($past(wdata) & rrpd_pkg::SEQ_WMASK))
      else $error("channel select write wrong");

   seq_reset_a: assert property ( // RQ6
      $rose(reset_n) |-> conv_chan_sel == rrpd_pkg::SEQ_RST &&
         readback_sel == rrpd_pkg::PTR_RST[3:0])
      else $error("reset value wrong");

endmodule : rrpd_regbank

// ---- rtl/rrpd_top.sv ----
// two-wire slave that decodes the pointer byte and returns readback words
//
// Functional notes
// RQ1: pointer upper nibble 7 selects control-register readback mode.
// RQ2: lower nibble picks register: 0 noop, 2 channel select, 3..7 others.
// RQ3: codes 8 to D return GPIO, power-down, open-drain, three-state regs.
// RQ4: noop is 16 bits, bits 10..0 read/write, no side effect, resets zero.
// RQ5: noop bits 15..11 are read-only and read zero.
// RQ6: 16-bit channel select register, resets zero, reserved bits read-only.
// RQ7: next read after a readback pointer returns 16 bits, high byte first.
`timescale 1ns/10ps
module rrpd_top #(
   parameter logic [6:0] DEV_ADDR = rrpd_pkg::DEV_ADDR_DEF
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [15:0] ext_rdata,
   output logic      [3:0]  readback_sel,
   output logic      [15:0] conv_chan_sel
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
      $error("device address lies in a reserved range");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [1:0]           scl_s;
      logic [1:0]           sda_s;
      logic                 scl_p;
      logic                 sda_p;
      rrpd_pkg::rrpd_state_t st;
      logic [3:0]           cnt;
      logic [7:0]           sh;
      logic                 rw;
      logic [1:0]           widx;
      logic                 rphase;
      logic                 nack;
      logic                 sda_oe;
      logic                 sda_out;
      logic                 ptr_wr;
      logic                 data_wr;
      logic [7:0]           hi;
      logic [15:0]          wdata;
   } rrpd_link_t;

   localparam rrpd_link_t LINK_RST = '{scl_s: 2'h3, sda_s: 2'h3,
      scl_p: 1'b1, sda_p: 1'b1, st: rrpd_pkg::ST_IDLE, default: '0};

   rrpd_link_t  q;
   rrpd_link_t  d;
   logic [15:0] rd_word;
   logic [7:0]  next_byte;
   logic        scl;
   logic        sda;
   logic        rise;
   logic        fall;
   logic        start;
   logic        stop;

   // only the second synchroniser stage feeds the edge detectors
   assign scl   = q.scl_s[1];
   assign sda   = q.sda_s[1];
   assign rise  = scl & ~q.scl_p;
   assign fall  = ~scl & q.scl_p;
   assign start = scl & q.scl_p & q.sda_p & ~sda;
   assign stop  = scl & q.scl_p & ~q.sda_p & sda;

   // high byte goes first after every start
   assign next_byte = q.rphase ? rd_word[7:0] : rd_word[15:8];   // RQ7

   always_comb begin
      d         = q;
      d.scl_s   = {q.scl_s[0], scl_in};
      d.sda_s   = {q.sda_s[0], sda_in};
      d.scl_p   = q.scl_s[1];
      d.sda_p   = q.sda_s[1];
      d.ptr_wr  = 1'b0;
      d.data_wr = 1'b0;
      d.sda_out = 1'b0;
      if (start) begin
         d.st     = rrpd_pkg::ST_ADDR;
         d.cnt    = 4'h0;
         d.sda_oe = 1'b0;
         d.widx   = rrpd_pkg::WIDX_PTR;
         d.rphase = 1'b0;
      end else if (stop) begin
         d.st     = rrpd_pkg::ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            rrpd_pkg::ST_IDLE: begin
            end
            rrpd_pkg::ST_ADDR, rrpd_pkg::ST_WR: begin
               if (rise && q.cnt != rrpd_pkg::BYTE_BITS) begin
                  d.sh  = {q.sh[6:0], sda};
                  d.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt == rrpd_pkg::BYTE_BITS) begin
                  if (q.st == rrpd_pkg::ST_ADDR) begin
                     // a foreign address is left unanswered until a start
                     if (q.sh[7:1] == DEV_ADDR) begin
                        d.rw     = q.sh[0];
                        d.st     = rrpd_pkg::ST_ACK;
                        d.sda_oe = 1'b1;
                     end else begin
                        d.st = rrpd_pkg::ST_IDLE;
                     end
                  end else begin
                     d.st     = rrpd_pkg::ST_ACK;
                     d.sda_oe = 1'b1;
                     unique case (q.widx)
                        rrpd_pkg::WIDX_PTR: begin
                           d.ptr_wr = 1'b1;                  // RQ1
                           d.widx   = rrpd_pkg::WIDX_HI;
                        end
                        rrpd_pkg::WIDX_HI: begin
                           d.hi   = q.sh;
                           d.widx = rrpd_pkg::WIDX_LO;
                        end
                        default: begin
                           d.data_wr = 1'b1;
                           d.wdata   = {q.hi, q.sh};
                           d.widx    = rrpd_pkg::WIDX_HI;
                        end
                     endcase
                  end
               end
            end
            rrpd_pkg::ST_ACK: begin
               if (fall) begin
                  d.cnt = 4'h0;
                  if (q.rw) begin
                     d.st     = rrpd_pkg::ST_RD;             // RQ7
                     d.sh     = next_byte;
                     d.sda_oe = ~next_byte[7];
                     d.rphase = ~q.rphase;
                  end else begin
                     d.st     = rrpd_pkg::ST_WR;
                     d.sda_oe = 1'b0;
                  end
               end
            end
            rrpd_pkg::ST_RD: begin
               if (rise) begin
                  d.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt == rrpd_pkg::BYTE_BITS) begin
                  d.st     = rrpd_pkg::ST_RACK;
                  d.sda_oe = 1'b0;
               end else if (fall && q.cnt != 4'h0) begin
                  d.sh     = {q.sh[6:0], 1'b0};
                  d.sda_oe = ~q.sh[6];
               end
            end
            rrpd_pkg::ST_RACK: begin
               if (rise) begin
                  d.nack = sda;
               end else if (fall) begin
                  if (q.nack) begin
                     d.st = rrpd_pkg::ST_IDLE;
                  end else begin
                     d.st     = rrpd_pkg::ST_RD;             // RQ7
                     d.cnt    = 4'h0;
                     d.sh     = next_byte;
                     d.sda_oe = ~next_byte[7];
                     d.rphase = ~q.rphase;
                  end
               end
            end
            default: begin
               d.st = rrpd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         q <= LINK_RST;
      end else begin
         q <= d;
      end
   end

   assign sda_oe  = q.sda_oe;
   assign sda_out = q.sda_out;

   // ****************************************
   // register bank
   // ****************************************
   rrpd_regbank u_bank (
      .core_clk      (core_clk),
      .reset_n       (reset_n),
      .ptr_wr        (q.ptr_wr),
      .ptr_byte      (q.sh),
      .data_wr       (q.data_wr),
      .wdata         (q.wdata),
      .ext_rdata     (ext_rdata),
      .rd_word       (rd_word),
      .readback_sel  (readback_sel),
      .conv_chan_sel (conv_chan_sel)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence first_load;
      q.st == rrpd_pkg::ST_ACK && q.rw && fall && !start && !stop;
   endsequence

   sequence second_load;
      q.st == rrpd_pkg::ST_RACK && fall && !q.nack && q.rphase &&
      !start && !stop;
   endsequence

   high_first_a: assert property ( // RQ7
      first_load |=> q.st == rrpd_pkg::ST_RD && sda_oe == ~rd_word[15])
      else $error("first read byte not high byte");

   low_second_a: assert property ( // RQ7
      second_load |=> q.st == rrpd_pkg::ST_RD && sda_oe == ~rd_word[7])
      else $error("second read byte not low byte");

   stop_release_a: assert property (
      stop |=> q.st == rrpd_pkg::ST_IDLE && !sda_oe)
      else $error("bus not released after stop");

endmodule : rrpd_top

// ---- test/rrpd_host.sv ----
// two-wire bus controller model that faces the block's data and clock pins
`timescale 1ns/10ps
module rrpd_host (
   input  wire logic core_clk,
   input  wire logic sda_wire,
   output logic      scl_low,
   output logic      sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   task automatic gap(input int n);
      repeat (n) @(negedge core_clk);
   endtask : gap

   // also serves as repeated start: data is re-raised while clock is low
   task automatic start_cond();
      gap(6);
      sda_low = 1'b0;
      gap(6);
      scl_low = 1'b0;
      gap(12);
      sda_low = 1'b1;
      gap(12);
      scl_low = 1'b1;
   endtask : start_cond

   task automatic stop_cond();
      gap(6);
      sda_low = 1'b1;
      gap(6);
      scl_low = 1'b0;
      gap(12);
      sda_low = 1'b0;
      gap(12);
   endtask : stop_cond

   // data moves mid-low, so hold after the clock fall is 6 clocks
   task automatic xfer(input logic [7:0] tx, input logic ninth,
                       output logic [7:0] rx, output logic ack_lvl);
      logic [8:0] bits;
      logic [8:0] got;
      bits = {tx, ninth};
      for (int i = 8; i >= 0; i--) begin
         gap(6);
         sda_low = ~bits[i];
         gap(6);
         scl_low = 1'b0;
         gap(6);
         got[i] = sda_wire;
         gap(6);
         scl_low = 1'b1;
      end
      rx      = got[8:1];
      ack_lvl = got[0];
   endtask : xfer

   // nack is high if any byte went unacknowledged
   task automatic write_frame(input logic [6:0] addr, input logic [7:0] ptr,
                              input logic with_data, input logic [15:0] data,
                              output logic nack);
      logic [7:0] rx;
      logic       a0, a1, a2, a3;
      start_cond();
      xfer({addr, 1'b0}, 1'b1, rx, a0);
      xfer(ptr, 1'b1, rx, a1);
      a2 = 1'b0;
      a3 = 1'b0;
      if (with_data) begin
         xfer(data[15:8], 1'b1, rx, a2);
         xfer(data[7:0], 1'b1, rx, a3);
      end
      stop_cond();
      nack = a0 | a1 | a2 | a3;
   endtask : write_frame

   task automatic read_word(input logic [6:0] addr, output logic [15:0] word,
                            output logic nack);
      logic [7:0] rx;
      logic       a;
      start_cond();
      xfer({addr, 1'b1}, 1'b1, rx, nack);
      xfer(8'hFF, 1'b0, word[15:8], a);
      xfer(8'hFF, 1'b1, word[7:0], a);
      stop_cond();
   endtask : read_word
endmodule : rrpd_host

// ---- test/register_readback_pointer_decode_bench.sv ----
// self-checking bench for the readback pointer decode block
`timescale 1ns/10ps
module register_readback_pointer_decode_bench;
   localparam logic [6:0] ADDR = rrpd_pkg::DEV_ADDR_DEF;
   logic        core_clk, reset_n, scl_low, sda_low, sda_out, sda_oe;
   logic        sda_wire, nack;
   logic [15:0] ext_rdata, conv_chan_sel, w;
   logic [3:0]  readback_sel;
   int          bad_count, compares;

   // open-drain wire with pull-up
   assign sda_wire = ~((sda_oe & ~sda_out) | sda_low);

   rrpd_top dut (
      .core_clk      (core_clk),
      .reset_n       (reset_n),
      .scl_in        (~scl_low),
      .sda_in        (sda_wire),
      .sda_out       (sda_out),
      .sda_oe        (sda_oe),
      .ext_rdata     (ext_rdata),
      .readback_sel  (readback_sel),
      .conv_chan_sel (conv_chan_sel)
   );

   rrpd_host host (
      .core_clk (core_clk),
      .sda_wire (sda_wire),
      .scl_low  (scl_low),
      .sda_low  (sda_low)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(string what, logic exp, logic got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // ****************************************
   // scenarios
   // ****************************************
   task automatic reset_state();
      host.read_word(ADDR, w, nack);
      check_bit("address ack", 1'b0, nack);
      check_word("noop at reset", 16'h0000, w);
      check_word("chan sel at reset", 16'h0000, conv_chan_sel);
      check_word("sel at reset", 16'h0000, {12'h000, readback_sel});
   endtask : reset_state

   task automatic noop_write();
      host.write_frame(ADDR, 8'h00, 1'b1, 16'hFFFF, nack);
      check_bit("noop write ack", 1'b0, nack);
      check_word("noop no side effect", 16'h0000, conv_chan_sel);
      host.write_frame(ADDR, 8'h70, 1'b0, 16'h0000, nack);
      host.read_word(ADDR, w, nack);
      check_word("noop masked", 16'h07FF, w);
   endtask : noop_write

   task automatic chan_write();
      host.write_frame(ADDR, 8'h02, 1'b1, 16'hABCD, nack);
      check_word("chan sel stored", 16'h00CD, conv_chan_sel);
      // data after a readback pointer is acked but must not land
      host.write_frame(ADDR, 8'h72, 1'b1, 16'h0033, nack);
      check_word("chan sel kept", 16'h00CD, conv_chan_sel);
      check_word("sel chan", 16'h0002, {12'h000, readback_sel});
      host.read_word(ADDR, w, nack);
      check_word("chan sel readback", 16'h00CD, w);
      check_bit("line freed", 1'b0, sda_oe);
      check_bit("drive level", 1'b0, sda_out);
   endtask : chan_write

   task automatic other_codes();
      logic [15:0] exp;
      for (int c = 3; c <= 13; c++) begin
         exp = {c[3:0], ~c[3:0], 8'hA5};
         ext_rdata = exp;
         host.write_frame(ADDR, {4'h7, c[3:0]}, 1'b0, 16'h0000, nack);
         check_word("sel code", {12'h000, c[3:0]}, 16'(readback_sel));
         host.read_word(ADDR, w, nack);
         check_word("code readback", exp, w);
      end
   endtask : other_codes

   // chan sel holds 0x00CD and ext_rdata is nonzero, so a zero word
   // shows the mode or unused code was refused
   task automatic wrong_mode();
      logic [7:0] ptrs [4];
      ptrs = '{8'h02, 8'h62, 8'h71, 8'h7E};
      foreach (ptrs[i]) begin
         host.write_frame(ADDR, ptrs[i], 1'b0, 16'h0000, nack);
         host.read_word(ADDR, w, nack);
         check_word("non readback mode", 16'h0000, w);
      end
      // a foreign address is left unanswered and moves no pointer
      host.write_frame(ADDR ^ 7'h01, 8'h72, 1'b0, 16'h0000, nack);
      check_bit("foreign addr nack", 1'b1, nack);
      check_word("sel kept", 16'h000E, {12'h000, readback_sel});
   endtask : wrong_mode

   initial begin
      repeat (90000) @(posedge core_clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      bad_count = 0;
      compares  = 0;
      reset_n   = 1'b0;
      ext_rdata = 16'h0000;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      reset_state();
      noop_write();
      chan_write();
      other_codes();
      wrong_mode();
      tally_and_finish();
   end
endmodule : register_readback_pointer_decode_bench
